// File: src/scsa_core.sv
// Call stack, error redirect and accumulator execution core.
// Assumes one command per cmd_valid pulse, issued by the sequencer on clk_sys,
// and that the sequencer follows jump_valid by loading jump_line or jump_label.
// DEPTH must be a power of two: the low pointer bits address the line memory.
module scsa_core
    import scsa_pkg::*;
#(
    parameter int DEPTH = SCSA_STACK_DEPTH
)
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       cmd_valid,
    input  wire scsa_pkg::scsa_cmd_t        cmd,
    input  wire scsa_pkg::scsa_op_t         op,
    input  wire logic [8:0]                 label,
    input  wire logic [15:0]                next_line,
    input  wire logic [31:0]                opnd_a,
    input  wire logic [31:0]                opnd_b,
    output logic                            jump_valid,
    output logic                            jump_is_label,
    output logic [8:0]                      jump_label,
    output logic [15:0]                     jump_line,
    output logic                            err_pulse,
    output logic                            rd_valid,
    output logic [31:0]                     rd_data,
    output logic [31:0]                     acc_value,
    output logic [8:0]                      stack_level
);
    import scsa_pkg::*;

    localparam int PTR_W = $clog2(DEPTH + 1);

    // Command match, shared by every strobe below
    function automatic logic cmd_is(
        input logic      valid,
        input scsa_cmd_t code,
        input scsa_cmd_t want
    );
        return valid && (code == want);
    endfunction

    logic [15:0]      stack_mem [DEPTH];
    logic [PTR_W-1:0] level_q;
    logic [31:0]      acc_q;
    logic [31:0]      alu_a;
    logic [31:0]      alu_res;
    logic             alu_dz;
    logic             full;
    logic             empty;
    logic             fault;
    logic             do_call;
    logic             do_ret;
    logic             do_read;
    logic [PTR_W-2:0] push_idx;
    logic [PTR_W-2:0] top_idx;

    assign full  = (level_q == PTR_W'(DEPTH));
    assign empty = (level_q == '0);

    // Decoded command strobes
    assign do_call = cmd_is(cmd_valid, cmd, SCSA_CMD_CALL);
    assign do_ret  = cmd_is(cmd_valid, cmd, SCSA_CMD_RETURN);
    assign do_read = cmd_is(cmd_valid, cmd, SCSA_CMD_ACC_READ);

    // Next free slot and top entry; a full stack wraps push_idx to zero,
    // which is harmless because pushes are blocked then
    assign push_idx = level_q[PTR_W-2:0];
    assign top_idx  = push_idx - (PTR_W-1)'(1);

    // Monadic forms use the accumulator as the first operand
    assign alu_a = (cmd == SCSA_CMD_ACC_MONADIC) ? acc_q : opnd_a;

    scsa_alu u_alu (
        .op       (op),
        .opnd_a   (alu_a),
        .opnd_b   (opnd_b),
        .result   (alu_res),
        .div_zero (alu_dz)
    );

    // Faults: stack overflow, underflow, divide by zero, or sequencer error
    always_comb
    begin
        fault = 1'b0;
        if (cmd_valid)
        begin
            unique case (cmd)
                SCSA_CMD_CALL:        fault = full;
                SCSA_CMD_RETURN:      fault = empty;
                SCSA_CMD_ACC_MONADIC: fault = alu_dz;
                SCSA_CMD_ACC_DYADIC:  fault = alu_dz;
                SCSA_CMD_ERROR:       fault = 1'b1;
                default:              fault = 1'b0;
            endcase
        end
    end

    // Return-line storage; no reset so it maps to memory
    // Only the slot being pushed is written, so lower entries stay intact
    // push following line
    always_ff @(posedge clk_sys)
    begin
        if (do_call && !full)
            stack_mem[push_idx] <= next_line;
    end

    // Stack level pointer
    // A refused push or pop leaves the level alone; the fault path reports it
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            level_q <= '0;
        else if (cmd_valid)
        begin
            unique case (cmd)
                SCSA_CMD_CALL:   if (!full) level_q <= level_q + PTR_W'(1);
                SCSA_CMD_RETURN: if (!empty) level_q <= level_q - PTR_W'(1);
                SCSA_CMD_CLEAR:  level_q <= '0;
                default:         level_q <= level_q;
            endcase
        end
    end

    // Jump request to the sequencer
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            jump_valid    <= 1'b0;
            jump_is_label <= 1'b0;
            jump_label    <= 9'h000;
            jump_line     <= 16'h0000;
        end
        else
        begin
            jump_valid <= 1'b0;
            // A fault outranks the call or return that caused it, so a refused
            // request only ever reports the error label
            if (fault)
            begin
                jump_valid    <= 1'b1;
                jump_is_label <= 1'b1;
                jump_label    <= SCSA_ERR_LABEL;
            end
            else if (do_call)
            begin
                jump_valid    <= 1'b1;
                jump_is_label <= 1'b1;
                jump_label    <= label;
            end
            else if (do_ret)
            begin
                jump_valid    <= 1'b1;
                jump_is_label <= 1'b0;
                jump_line     <= stack_mem[top_idx];
            end
        end
    end

    // Error pulse mirrors the redirect
    // Kept apart from jump_valid so a monitor can count faults alone
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            err_pulse <= 1'b0;
        else
            err_pulse <= fault;
    end

    // Accumulator; returns never touch it, faulting operations leave it as is
    // signed 32-bit holding
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            acc_q <= SCSA_ACC_RST;
        else if (cmd_valid && !fault)
        begin
            unique case (cmd)
                SCSA_CMD_ACC_LOAD:    acc_q <= opnd_b;
                SCSA_CMD_ACC_MONADIC: acc_q <= alu_res;
                SCSA_CMD_ACC_DYADIC:  acc_q <= alu_res;
                default:              acc_q <= acc_q;
            endcase
        end
    end

    // Read-back of the accumulator
    // return present value
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rd_valid <= 1'b0;
            rd_data  <= 32'h0000_0000;
        end
        else
        begin
            rd_valid <= do_read;
            if (do_read)
                rd_data <= acc_q;
        end
    end

    assign acc_value   = acc_q;
    assign stack_level = 9'(level_q);
endmodule // scsa_core

// File: src/scsa_pkg.sv
// Shared constants and types for the sequence call stack and accumulator core.
// Assumes a host-side decoder resolves register operands to values before issue.
// Summary of operation
// - Call pushes next line, jumps to label
// - Return pops top line and resumes there
// - Nesting supported to 256 stack levels
// - Errors redirect execution to label 80
// - Error redirect keeps existing stack entries
// - Stack clear empties all levels at once
// - Return leaves accumulator value untouched
// - Accumulator access loads or reads value
// - Add, sub, mul, div monadic and dyadic
// - Not, and, or, and-not, or-not, shifts
// - Operands are immediates or register contents
package scsa_pkg;
    localparam int          SCSA_STACK_DEPTH = 256;
    localparam int          SCSA_LINE_W      = 16;
    localparam int          SCSA_LABEL_W     = 9;
    localparam int          SCSA_ACC_W       = 32;
    localparam logic [8:0]  SCSA_ERR_LABEL   = 9'h050;
    localparam logic [31:0] SCSA_ACC_RST     = 32'h0000_0000;

    // Commands presented by the sequencer front end
    typedef enum logic [3:0] {
        SCSA_CMD_CALL,
        SCSA_CMD_RETURN,
        SCSA_CMD_CLEAR,
        SCSA_CMD_ACC_LOAD,
        SCSA_CMD_ACC_READ,
        SCSA_CMD_ACC_MONADIC,
        SCSA_CMD_ACC_DYADIC,
        SCSA_CMD_ERROR
    } scsa_cmd_t;

    // Operation selector for accumulator arithmetic and logic
    typedef enum logic [3:0] {
        SCSA_OP_ADD,
        SCSA_OP_SUB,
        SCSA_OP_MUL,
        SCSA_OP_DIV,
        SCSA_OP_NOT,
        SCSA_OP_AND,
        SCSA_OP_OR,
        SCSA_OP_ANDN,
        SCSA_OP_ORN,
        SCSA_OP_SHR,
        SCSA_OP_SHL
    } scsa_op_t;
endpackage

// File: src/scsa_alu.sv
// Combinational accumulator arithmetic and logic unit.
// Assumes operands already hold resolved signed 32-bit values.
module scsa_alu
    import scsa_pkg::*;
(
    input  wire scsa_pkg::scsa_op_t op,
    input  wire logic [31:0]        opnd_a,
    input  wire logic [31:0]        opnd_b,
    output logic [31:0]             result,
    output logic                    div_zero
);
    import scsa_pkg::*;

    logic signed [63:0] prod;

    // Products wrap to the accumulator width; division by zero is flagged
    // arithmetic and logic operations
    always_comb
    begin
        prod     = $signed(opnd_a) * $signed(opnd_b);
        div_zero = 1'b0;
        result   = 32'h0000_0000;
        unique case (op)
            SCSA_OP_ADD:  result = opnd_a + opnd_b;
            SCSA_OP_SUB:  result = opnd_a - opnd_b;
            SCSA_OP_MUL:  result = prod[31:0];
            SCSA_OP_DIV:
            begin
                div_zero = (opnd_b == 32'h0000_0000);
                if (!div_zero)
                    result = 32'($signed(opnd_a) / $signed(opnd_b));
            end
            SCSA_OP_NOT:  result = ~opnd_b;
            SCSA_OP_AND:  result = opnd_a & opnd_b;
            SCSA_OP_OR:   result = opnd_a | opnd_b;
            SCSA_OP_ANDN: result = opnd_a & ~opnd_b;
            SCSA_OP_ORN:  result = opnd_a | ~opnd_b;
            SCSA_OP_SHR:  result = 32'($signed(opnd_a) >>> opnd_b[4:0]);
            SCSA_OP_SHL:  result = opnd_a << opnd_b[4:0];
            default:      div_zero = 1'b0;
        endcase
    end
endmodule // scsa_alu

// File: verif/scsa_checker.sv
// Port checker for the call stack and accumulator core.
// Assumes it is bound to scsa_core; reset aborts every check.
module scsa_checker
    import scsa_pkg::*;
#(
    parameter int DEPTH = SCSA_STACK_DEPTH
)
(
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                cmd_valid,
    input wire scsa_pkg::scsa_cmd_t cmd,
    input wire logic [8:0]          label,
    input wire logic                jump_valid,
    input wire logic                jump_is_label,
    input wire logic [8:0]          jump_label,
    input wire logic                err_pulse,
    input wire logic                rd_valid,
    input wire logic [31:0]         rd_data,
    input wire logic [31:0]         acc_value,
    input wire logic [8:0]          stack_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Command taken at this edge, and the error redirect one cycle later
    sequence s_cmd(scsa_cmd_t k); cmd_valid && cmd == k; endsequence
    sequence s_err; err_pulse && jump_valid && jump_is_label && jump_label == SCSA_ERR_LABEL;
    endsequence
    call_jump_a: assert property (s_cmd(SCSA_CMD_CALL) ##0 stack_level < DEPTH |=>
        jump_valid && jump_is_label && jump_label == $past(label) &&
        stack_level == $past(stack_level) + 1) else $error("bad call");
    ret_pop_a: assert property (s_cmd(SCSA_CMD_RETURN) ##0 stack_level > 0 |=>
        jump_valid && !jump_is_label && stack_level == $past(stack_level) - 1 &&
        $stable(acc_value)) else $error("bad return");
    err_keep_a: assert property (s_cmd(SCSA_CMD_ERROR) |=> s_err ##0 $stable(stack_level))
        else $error("bad error redirect");
    clear_all_a: assert property (s_cmd(SCSA_CMD_CLEAR) |=> stack_level == 0)
        else $error("stack not cleared");
    read_acc_a: assert property (s_cmd(SCSA_CMD_ACC_READ) |=> rd_valid && rd_data == acc_value)
        else $error("bad read");
    full_push_a: assert property (s_cmd(SCSA_CMD_CALL) ##0 stack_level == DEPTH |=>
        s_err ##0 $stable(stack_level)) else $error("overflow not refused");
    empty_ret_a: assert property (s_cmd(SCSA_CMD_RETURN) ##0 stack_level == 0 |=>
        s_err ##0 stack_level == 0) else $error("underflow not refused");
    level_max_a: assert property (stack_level <= DEPTH) else $error("level too high");
endmodule // scsa_checker

bind scsa_core scsa_checker #(.DEPTH(DEPTH)) u_chk (.clk_sys, .rst, .cmd_valid, .cmd, .label,
    .jump_valid, .jump_is_label, .jump_label, .err_pulse, .rd_valid, .rd_data, .acc_value,
    .stack_level);

// File: verif/scsa_host_model.sv
// Host model that issues sequence commands to the core.
// Assumes the bench calls send once per command and reads the answer after it.
module scsa_host_model
    import scsa_pkg::*;
(
    input  wire logic           clk_sys,
    output logic                cmd_valid,
    output scsa_pkg::scsa_cmd_t cmd,
    output scsa_pkg::scsa_op_t  op,
    output logic [8:0]          label,
    output logic [15:0]         next_line,
    output logic [31:0]         opnd_a,
    output logic [31:0]         opnd_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle values before the first command
    initial
    begin
        {cmd_valid, label, next_line, opnd_a, opnd_b} = '0;
        cmd = SCSA_CMD_ACC_READ;
        op = SCSA_OP_ADD;
    end
    // host never self-calls, never clears inside a returning routine
    // One-cycle strobe; #1 lets the answer settle before the caller looks
    task automatic send(input scsa_cmd_t c, input scsa_op_t o, input logic [8:0] l,
        input logic [15:0] n, input logic [31:0] a, input logic [31:0] b);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        {cmd, op, label, next_line, opnd_a, opnd_b} <= {c, o, l, n, a, b};
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1;
    endtask
endmodule // scsa_host_model

// File: verif/tb_sequence_call_stack_accumulator.sv
// Self-checking bench for the call stack and accumulator core.
// Assumes the host model issues commands; depth 4 stands in for 256.
module tb_sequence_call_stack_accumulator;
    timeunit 1ns;
    timeprecision 1ps;
    import scsa_pkg::*;
    localparam int DEPTH = 4;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid, jump_valid, jump_is_label, err_pulse, rd_valid;
    scsa_cmd_t   cmd;
    scsa_op_t    op;
    logic [8:0]  label, jump_label, stack_level;
    logic [15:0] next_line, jump_line;
    logic [31:0] opnd_a, opnd_b, rd_data, acc_value;
    int          err_total = 0;
    int          checked = 0;

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;
    scsa_host_model host (.clk_sys, .cmd_valid, .cmd, .op, .label, .next_line, .opnd_a, .opnd_b);
    scsa_core #(.DEPTH(DEPTH)) dut (.clk_sys, .rst, .cmd_valid, .cmd, .op, .label, .next_line,
        .opnd_a, .opnd_b, .jump_valid, .jump_is_label, .jump_label, .jump_line, .err_pulse,
        .rd_valid, .rd_data, .acc_value, .stack_level);

    // Case equality so an unknown never matches
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic redir(input string what);
        chk(what, {err_pulse, jump_valid, jump_is_label, jump_label}, {3'b111, SCSA_ERR_LABEL});
    endtask
    task automatic go(input scsa_cmd_t c, input logic [8:0] l = 0, input logic [15:0] n = 0);
        host.send(c, SCSA_OP_ADD, l, n, 32'h0, 32'h0);
    endtask
    // Hand-worked results for -13 in the accumulator and 5 as operand, by op code;
    // the dyadic row swaps the operands and its entry for not is never checked
    localparam logic [31:0] MON_EXP [11] = '{32'hffff_fff8, 32'hffff_ffee, 32'hffff_ffbf,
        32'hffff_fffe, 32'hffff_fffa, 32'h0000_0001, 32'hffff_fff7, 32'hffff_fff2,
        32'hffff_fffb, 32'hffff_ffff, 32'hffff_fe60};
    localparam logic [31:0] DYA_EXP [11] = '{32'hffff_fff8, 32'h0000_0012, 32'hffff_ffbf,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'hffff_fff7, 32'h0000_0004,
        32'h0000_000d, 32'h0000_0000, 32'h0028_0000};

    // Nest to full depth up to label 511, change acc deep inside, unwind
    task automatic t_nest();
        for (int i = 0; i < DEPTH; i++)
        begin
            go(SCSA_CMD_CALL, 9'(508 + i), 16'(20 + i));
            chk("call", {err_pulse, jump_valid, jump_is_label, jump_label, stack_level},
                {3'b011, 9'(508 + i), 9'(i + 1)});
        end
        host.send(SCSA_CMD_ACC_DYADIC, SCSA_OP_ADD, 9'h0, 16'h0, 32'h1, 32'h2);
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            go(SCSA_CMD_RETURN);
            chk("return", {jump_valid, jump_is_label, jump_line, stack_level},
                {2'b10, 16'(20 + i), 9'(i)});
            chk("acc kept", acc_value, 32'h3);
        end
        go(SCSA_CMD_ACC_READ);
        chk("read", {rd_valid, rd_data}, {1'b1, 32'h3});
        $display("nest test done");
    endtask

    // Overflow, error redirect with stack kept, clear, then underflow
    task automatic t_fault();
        for (int i = 0; i < DEPTH; i++)
            go(SCSA_CMD_CALL, 9'h1, 16'(i));
        go(SCSA_CMD_CALL, 9'h2, 16'h9);
        redir("overflow");
        chk("full kept", stack_level, DEPTH);
        go(SCSA_CMD_ERROR);
        redir("error");
        chk("err kept", stack_level, DEPTH);
        // Every stored line must survive the refused push and the redirect
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            go(SCSA_CMD_RETURN);
            chk("kept line", jump_line, 16'(i));
        end
        go(SCSA_CMD_CALL, 9'h3, 16'h30);
        go(SCSA_CMD_CALL, 9'h4, 16'h31);
        go(SCSA_CMD_CLEAR);
        chk("clear", stack_level, 0);
        go(SCSA_CMD_RETURN);
        redir("underflow");
        $display("fault test done");
    endtask

    // Every operation monadic, then dyadic with swapped operands for all but not
    task automatic t_alu();
        logic [31:0] a;
        logic [31:0] b;
        scsa_op_t    o;
        a = 32'hffff_fff3;
        b = 32'h0000_0005;
        for (int i = 0; i <= 10; i++)
        begin
            o = scsa_op_t'(i);
            host.send(SCSA_CMD_ACC_LOAD, o, 9'h0, 16'h0, 32'h0, a);
            chk("load", acc_value, a);
            host.send(SCSA_CMD_ACC_MONADIC, o, 9'h0, 16'h0, 32'h0, b);
            chk("monadic", acc_value, MON_EXP[i]);
            if (o != SCSA_OP_NOT)
            begin
                host.send(SCSA_CMD_ACC_DYADIC, o, 9'h0, 16'h0, b, a);
                chk("dyadic", acc_value, DYA_EXP[i]);
            end
        end
        host.send(SCSA_CMD_ACC_DYADIC, SCSA_OP_DIV, 9'h0, 16'h0, a, 32'h0);
        redir("div zero");
        chk("div kept", acc_value, 32'h0028_0000);
        $display("alu test done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_nest();
        t_fault();
        t_alu();
        end_of_test();
    end
    // Watchdog, well past the roughly 120 cycles the tests need
    initial
    begin
        #20000;
        err_total++;
        end_of_test();
    end
endmodule // tb_sequence_call_stack_accumulator
